// ### core/isp_pkg.sv
/*
 * Shared constants, frame layouts and state encodings of the serial
 * in-system programming port.
 * Assumes a 50 MHz system clock and a four-byte, MSB-first link.
 */
package isp_pkg;

	// System clock rate and unit conversion.
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int CYCLES_PER_US = SYS_CLK_HZ / US_PER_S;

	// Self-timed write windows in microseconds.
	localparam int WRITE_MIN_US = 3700;
	localparam int WRITE_MAX_US = 4500;
	localparam int ERASE_MIN_US = 7500;
	localparam int ERASE_MAX_US = 9000;
	localparam int WRITE_TARGET_US = (WRITE_MIN_US + WRITE_MAX_US) / 2;
	localparam int ERASE_TARGET_US = (ERASE_MIN_US + ERASE_MAX_US) / 2;
	localparam int WRITE_CYCLES_DEF = WRITE_TARGET_US * CYCLES_PER_US;
	localparam int ERASE_CYCLES_DEF = ERASE_TARGET_US * CYCLES_PER_US;
	localparam int TIMER_W = 24;

	// Link framing.
	localparam int FRAME_LEN = 32;
	localparam int HDR_BITS = 24;
	localparam int COUNT_W = 5;
	localparam int BYTE_AW = 3;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 5'h01;
	localparam logic [COUNT_W-1:0] COUNT_LAST = 5'h1F;
	localparam logic [1:0] IDX_FIRST = 2'h0;
	localparam logic [1:0] IDX_DATA = 2'h3;

	// Memory organisation.
	localparam int PAGE_AW = 7;
	localparam int PAGE_WORDS = 128;
	localparam int FLASH_AW_DEF = 14;
	localparam int EE_AW_DEF = 10;
	localparam int EE_PAW = 2;
	localparam int EE_PAGE = 4;
	localparam int OP_HIGH_BIT = 3;
	localparam int CLK_SRC_W = 4;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	// Instruction codes, first byte.
	localparam logic [7:0] OP_ENABLE = 8'hAC;
	localparam logic [7:0] OP_EXT_ADDR = 8'h4D;
	localparam logic [7:0] OP_READ_PROG_LO = 8'h20;
	localparam logic [7:0] OP_READ_PROG_HI = 8'h28;
	localparam logic [7:0] OP_LOAD_PAGE_LO = 8'h40;
	localparam logic [7:0] OP_LOAD_PAGE_HI = 8'h48;
	localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
	localparam logic [7:0] OP_READ_EE = 8'hA0;
	localparam logic [7:0] OP_WRITE_EE = 8'hC0;
	localparam logic [7:0] OP_LOAD_EE_PAGE = 8'hC1;
	localparam logic [7:0] OP_WRITE_EE_PAGE = 8'hC2;
	localparam logic [7:0] OP_READ_LOCK = 8'h58;
	localparam logic [7:0] OP_READ_FUSE = 8'h50;
	localparam logic [7:0] OP_SIGNATURE = 8'h30;
	localparam logic [7:0] OP_CALIB = 8'h38;
	localparam logic [7:0] OP_POLL = 8'hF0;

	// Second-byte selectors.
	localparam logic [7:0] ENABLE_ECHO = 8'h53;
	localparam logic [2:0] SUB_ERASE = 3'h4;
	localparam logic [2:0] SUB_LOCK = 3'h7;
	localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
	localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
	localparam logic [7:0] SUB_FUSE_EXT = 8'hA4;
	localparam logic [7:0] SEL_HIGH = 8'h08;

	// Power-on contents; identity values are arbitrary.
	localparam logic [7:0] FUSE_LOW_INIT = 8'hFF;
	localparam logic [7:0] FUSE_HIGH_INIT = 8'hFF;
	localparam logic [7:0] FUSE_EXT_INIT = 8'hFF;
	localparam logic [7:0] LOCK_INIT = 8'hFF;
	localparam logic [7:0] SIG_BYTE0 = 8'h11;
	localparam logic [7:0] SIG_BYTE1 = 8'h22;
	localparam logic [7:0] SIG_BYTE2 = 8'h33;
	localparam logic [7:0] CALIB_BYTE = 8'h80;

	typedef struct packed {
		logic [7:0] op;
		logic [7:0] addrHi;
		logic [7:0] addrLo;
		logic [7:0] data;
	} isp_frame_type;

	typedef struct packed {
		logic [7:0] op;
		logic [7:0] addrHi;
		logic [7:0] addrLo;
	} isp_header_type;

	typedef enum logic [1:0] {
		TMR_IDLE = 2'b01,
		TMR_BUSY = 2'b10
	} isp_timer_state_type;

endpackage : isp_pkg

// ### core/isp_link_shifter.sv
/*
 * Bit framing of the programming link: input shift register, bit
 * counter and output shifter, all on the link's serial clock.
 * Assumes the clock idles low between frames and linkClear is held
 * high whenever the device is not in programming reset.
 */
`timescale 1ns/1ps
module isp_link_shifter
	import isp_pkg::*;
(
	// Link clock and framing reset.
	input wire logic serialClock,
	input wire logic linkClear,
	// Serial data.
	input wire logic serialIn,
	output logic serialOut,
	// Frame state towards the decoder.
	input wire logic [7:0] respByte,
	output logic [FRAME_LEN-1:0] rxBits,
	output logic [FRAME_LEN-1:0] frameNext,
	output logic [COUNT_W-1:0] bitCount,
	output logic lastBit
);

	logic [7:0] outShift;
	logic byteStart;

	assign frameNext = {rxBits[FRAME_LEN-2:0], serialIn};
	assign lastBit = (bitCount == COUNT_LAST);
	assign byteStart = (bitCount[BYTE_AW-1:0] == 3'h0);
	assign serialOut = outShift[7];

	always_ff @(posedge serialClock or posedge linkClear) begin
		if (linkClear) begin
			rxBits <= '0;
			bitCount <= '0;
		end else begin
			rxBits <= frameNext;
			bitCount <= bitCount + COUNT_ONE;
		end
	end

	// The answer byte is loaded on the falling edge that ends a byte, so
	// its first bit is settled before the next rising edge samples it.
	always_ff @(negedge serialClock or posedge linkClear) begin
		if (linkClear) begin
			outShift <= 8'h00;
		end else if (byteStart) begin
			outShift <= respByte;
		end else begin
			outShift <= {outShift[6:0], 1'b0};
		end
	end

endmodule : isp_link_shifter

// ### core/isp_port.sv
/*
 * Serial in-system programming port: instruction decode, Flash page
 * buffer, Flash and EEPROM arrays, fuse and lock bytes on the link
 * clock, and the self-timed write timer on the system clock.
 * Assumes the programmer keeps the link timing and waits below.
 */
`timescale 1ns/1ps
module isp_port
	import isp_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
	parameter int FLASH_AW = FLASH_AW_DEF,
	parameter int EE_AW = EE_AW_DEF
) (
	// System clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Programming link pins.
	input wire logic serialClock,
	input wire logic progResetN,
	input wire logic progSerialIn,
	output logic progSerialOut,
	// Status towards the rest of the chip.
	output logic writeDoneFlag,
	output logic cpuRun,
	output logic [CLK_SRC_W-1:0] clockSourceFuses
);

	localparam int FLASH_WORDS = 2 ** FLASH_AW;
	localparam int EE_BYTES = 2 ** EE_AW;
	localparam logic [TIMER_W-1:0] WRITE_LOAD = TIMER_W'(WRITE_CYCLES - 1);
	localparam logic [TIMER_W-1:0] ERASE_LOAD = TIMER_W'(ERASE_CYCLES - 1);
	localparam logic [TIMER_W-1:0] TIMER_ONE = 24'h000001;
	// System-domain state.
	logic sysRstReg, rstSync1, rstSync2;
	logic wSync1, wSync2, wSync3, ackToggle, next_ack, writeEdge;
	logic [TIMER_W-1:0] timer, next_timer;
	isp_timer_state_type state, next_state;
	// Link-domain state.
	logic linkClear, memClear, lastBit, progEnabled, busyLink;
	logic writeToggle, eraseKind, ackSync1, ackSync2;
	logic [FRAME_LEN-1:0] rxBits, frameNext;
	logic [COUNT_W-1:0] bitCount;
	logic [7:0] respByte, extAddr, fuseLow, fuseHigh, fuseExt, lockBits;
	isp_frame_type fr;
	isp_header_type hdr;
	// Memories.
	logic [15:0] flashMem [FLASH_WORDS], pageWord [PAGE_WORDS];
	logic [FLASH_WORDS-1:0] flashValid;
	logic [7:0] eeMem [EE_BYTES];
	logic [EE_BYTES-1:0] eeValid;
	logic [7:0] pageLo [PAGE_WORDS], pageHi [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] loadedLo, loadedHi;
	logic [7:0] eePage [EE_PAGE];
	logic [EE_PAGE-1:0] eePageLoaded;
	// Decoded instruction at the last rising edge of a frame.
	logic cmdLive, isWide, doEnable, doErase, doLock, doExt;
	logic doFuseLo, doFuseHi, doFuseExt, doLoadPage, doWritePage;
	logic doWriteEe, doLoadEePage, doWriteEePage, startTimed;
	logic [HDR_BITS-1:0] wrAddrFull;
	logic [FLASH_AW-PAGE_AW-1:0] pageSel;
	logic [PAGE_AW-1:0] pageIdx;
	logic [EE_AW-1:0] eeWrAddr, eeRdAddr;
	logic [EE_AW-EE_PAW-1:0] eePageSel;
	logic [EE_PAW-1:0] eePageIdx;
	logic [FLASH_AW-1:0] flashRdAddr;
	logic [15:0] flashRdWord;
	logic [7:0] flashRdByte, eeRdByte, sigByte, dataRaw, dataResp;
	logic isFlashRead;
	isp_link_shifter i_isp_link_shifter (
		.serialClock(serialClock), .linkClear(linkClear),
		.serialIn(progSerialIn), .serialOut(progSerialOut),
		.respByte(respByte), .rxBits(rxBits), .frameNext(frameNext),
		.bitCount(bitCount), .lastBit(lastBit)
	);

	// Reset high clears framing, so a pulse realigns the bit counter.
	assign linkClear = progResetN | sysRstReg;
	assign memClear = sysRstReg;
	assign fr = frameNext;
	assign hdr = rxBits[HDR_BITS-1:0];

	assign cmdLive = lastBit & progEnabled;
	assign isWide = cmdLive & (fr.op == OP_ENABLE);
	assign doEnable = lastBit & (fr.op == OP_ENABLE)
		& (fr.addrHi == ENABLE_ECHO);
	assign doErase = isWide & (fr.addrHi[7:5] == SUB_ERASE);
	assign doLock = isWide & (fr.addrHi[7:5] == SUB_LOCK);
	assign doFuseLo = isWide & (fr.addrHi == SUB_FUSE_LO);
	assign doFuseHi = isWide & (fr.addrHi == SUB_FUSE_HI);
	assign doFuseExt = isWide & (fr.addrHi == SUB_FUSE_EXT);
	assign doExt = cmdLive & (fr.op == OP_EXT_ADDR);
	assign doLoadPage = cmdLive & ((fr.op == OP_LOAD_PAGE_LO)
		| (fr.op == OP_LOAD_PAGE_HI));
	assign doWritePage = cmdLive & (fr.op == OP_WRITE_PAGE);
	assign doWriteEe = cmdLive & (fr.op == OP_WRITE_EE);
	assign doLoadEePage = cmdLive & (fr.op == OP_LOAD_EE_PAGE);
	assign doWriteEePage = cmdLive & (fr.op == OP_WRITE_EE_PAGE);
	assign startTimed = doErase | doLock | doFuseLo | doFuseHi | doFuseExt
		| doWritePage | doWriteEe | doWriteEePage;

	assign wrAddrFull = {extAddr, fr.addrHi, fr.addrLo};
	assign pageSel = wrAddrFull[FLASH_AW-1:PAGE_AW];
	assign pageIdx = fr.addrLo[PAGE_AW-1:0];
	assign eeWrAddr = EE_AW'({fr.addrHi[3:0], fr.addrLo});
	assign eePageSel = eeWrAddr[EE_AW-1:EE_PAW];
	assign eePageIdx = fr.addrLo[7:6];

	// Bytes never loaded since the last page write program as erased.
	for (genvar w = 0; w < PAGE_WORDS; w++) begin : g_page
		assign pageWord[w] = {loadedHi[w] ? pageHi[w] : ERASED_BYTE,
			loadedLo[w] ? pageLo[w] : ERASED_BYTE};
	end

	assign flashRdAddr = FLASH_AW'({extAddr, hdr.addrHi, hdr.addrLo});
	assign flashRdWord = flashValid[flashRdAddr] ? flashMem[flashRdAddr]
		: ERASED_WORD;
	assign flashRdByte = hdr.op[OP_HIGH_BIT] ? flashRdWord[15:8]
		: flashRdWord[7:0];
	assign eeRdAddr = EE_AW'({hdr.addrHi[3:0], hdr.addrLo});
	assign eeRdByte = eeValid[eeRdAddr] ? eeMem[eeRdAddr] : ERASED_BYTE;
	assign sigByte = (hdr.addrLo[1:0] == 2'h0) ? SIG_BYTE0
		: (hdr.addrLo[1:0] == 2'h1) ? SIG_BYTE1 : SIG_BYTE2;
	assign isFlashRead = ((hdr.op & ~SEL_HIGH) == OP_READ_PROG_LO);
	assign busyLink = writeToggle ^ ackSync2;

	assign dataRaw = isFlashRead ? flashRdByte
		: (hdr.op == OP_READ_EE) ? eeRdByte
		: (hdr.op == OP_POLL) ? {7'h00, busyLink}
		: (hdr.op == OP_SIGNATURE) ? sigByte
		: (hdr.op == OP_CALIB) ? CALIB_BYTE
		: ((hdr.op == OP_READ_LOCK) & (hdr.addrHi == SEL_HIGH)) ? fuseHigh
		: (hdr.op == OP_READ_LOCK) ? lockBits
		: ((hdr.op == OP_READ_FUSE) & (hdr.addrHi == SEL_HIGH)) ? fuseExt
		: (hdr.op == OP_READ_FUSE) ? fuseLow
		: hdr.addrLo;
	assign dataResp = progEnabled ? dataRaw : hdr.addrLo;

	// Each answer byte echoes the byte just received, except the first,
	// which is zero, and the fourth, which carries read data.
	assign respByte = (bitCount[COUNT_W-1:BYTE_AW] == IDX_DATA) ? dataResp
		: (bitCount[COUNT_W-1:BYTE_AW] == IDX_FIRST) ? 8'h00
		: hdr.addrLo;

	assign clockSourceFuses = fuseLow[CLK_SRC_W-1:0];

	// Session state, cleared whenever reset is released.
	always_ff @(posedge serialClock or posedge linkClear) begin
		if (linkClear) begin
			progEnabled <= 1'b0;
			extAddr <= 8'h00;
			loadedLo <= '0;
			loadedHi <= '0;
			eePageLoaded <= '0;
		end else begin
			if (doEnable) begin
				progEnabled <= 1'b1;
			end
			if (doExt) begin
				extAddr <= fr.addrLo;
			end
			if (doWritePage) begin
				loadedLo <= '0;
				loadedHi <= '0;
			end else if (doLoadPage & fr.op[OP_HIGH_BIT]) begin
				loadedHi[pageIdx] <= 1'b1;
			end else if (doLoadPage) begin
				loadedLo[pageIdx] <= 1'b1;
			end
			if (doWriteEePage) begin
				eePageLoaded <= '0;
			end else if (doLoadEePage) begin
				eePageLoaded[eePageIdx] <= 1'b1;
			end
		end
	end

	// Array contents; erased state is kept in the valid vectors below.
	always_ff @(posedge serialClock) begin
		if (doLoadPage & fr.op[OP_HIGH_BIT]) begin
			pageHi[pageIdx] <= fr.data;
		end else if (doLoadPage) begin
			pageLo[pageIdx] <= fr.data;
		end
		if (doWritePage) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				flashMem[{pageSel, PAGE_AW'(i)}] <= pageWord[i];
			end
		end
		if (doWriteEe) begin
			eeMem[eeWrAddr] <= fr.data;
		end
		if (doLoadEePage) begin
			eePage[eePageIdx] <= fr.data;
		end
		if (doWriteEePage) begin
			for (int j = 0; j < EE_PAGE; j++) begin
				if (eePageLoaded[j]) begin
					eeMem[{eePageSel, EE_PAW'(j)}] <= eePage[j];
				end
			end
		end
	end

	// Non-volatile state survives a programming reset; only the system
	// reset clears it, which makes the arrays read as erased. Completion
	// returns as a toggle, so a poll is fresh only after two link edges.
	always_ff @(posedge serialClock or posedge memClear) begin
		if (memClear) begin
			flashValid <= '0;
			eeValid <= '0;
			fuseLow <= FUSE_LOW_INIT;
			fuseHigh <= FUSE_HIGH_INIT;
			fuseExt <= FUSE_EXT_INIT;
			lockBits <= LOCK_INIT;
			writeToggle <= 1'b0;
			eraseKind <= 1'b0;
			ackSync1 <= 1'b0;
			ackSync2 <= 1'b0;
		end else begin
			ackSync1 <= ackToggle;
			ackSync2 <= ackSync1;
			if (doErase) begin
				flashValid <= '0;
				eeValid <= '0;
				lockBits <= ERASED_BYTE;
			end else begin
				if (doWritePage) begin
					flashValid[{pageSel, PAGE_AW'(0)} +: PAGE_WORDS] <= '1;
				end
				if (doWriteEe) begin
					eeValid[eeWrAddr] <= 1'b1;
				end
				if (doWriteEePage) begin
					for (int j = 0; j < EE_PAGE; j++) begin
						if (eePageLoaded[j]) begin
							eeValid[{eePageSel, EE_PAW'(j)}] <= 1'b1;
						end
					end
				end
				if (doLock) begin
					lockBits <= fr.data;
				end
			end
			if (doFuseLo) begin
				fuseLow <= fr.data;
			end
			if (doFuseHi) begin
				fuseHigh <= fr.data;
			end
			if (doFuseExt) begin
				fuseExt <= fr.data;
			end
			if (startTimed) begin
				writeToggle <= ~writeToggle;
				eraseKind <= doErase;
			end
		end
	end

	assign cpuRun = rstSync2;
	assign writeEdge = wSync2 ^ wSync3;

	// The erase flag is steady long before its toggle edge is seen here.
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_ack = ackToggle;
		unique case (state)
			TMR_IDLE: begin
				if (writeEdge) begin
					next_state = TMR_BUSY;
					next_timer = eraseKind ? ERASE_LOAD : WRITE_LOAD;
				end
			end
			TMR_BUSY: begin
				if (timer == '0) begin
					next_state = TMR_IDLE;
					next_ack = wSync3;
				end else begin
					next_timer = timer - TIMER_ONE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		sysRstReg <= sys_rst;
		if (sys_rst) begin
			rstSync1 <= 1'b1;
			rstSync2 <= 1'b1;
			wSync1 <= 1'b0;
			wSync2 <= 1'b0;
			wSync3 <= 1'b0;
			state <= TMR_IDLE;
			timer <= '0;
			ackToggle <= 1'b0;
			writeDoneFlag <= 1'b1;
		end else begin
			rstSync1 <= progResetN;
			rstSync2 <= rstSync1;
			wSync1 <= writeToggle;
			wSync2 <= wSync1;
			wSync3 <= wSync2;
			state <= next_state;
			timer <= next_timer;
			ackToggle <= next_ack;
			writeDoneFlag <= (next_state == TMR_IDLE);
		end
	end

endmodule : isp_port

// ### sim/isp_prog_model.sv
/*
 * Programmer model: clocks one four-byte frame per start request.
 * Assumes start is held until done is seen high, then dropped.
 */
`timescale 1ns/1ps
module isp_prog_model
	import isp_pkg::*;
(
	// Request side.
	input wire logic clock,
	input wire logic start,
	input wire isp_frame_type txFrame,
	output isp_frame_type rxFrame,
	output logic done,
	// Link side.
	output logic serialClock,
	output logic progSerialIn,
	input wire logic progSerialOut
);
	initial begin
		serialClock = 1'b0;
		progSerialIn = 1'b0;
		done = 1'b0;
		rxFrame = '0;
	end
	always begin
		@(posedge clock iff start);
		for (int i = FRAME_LEN - 1; i >= 0; i--) begin
			progSerialIn = txFrame[i];
			#6 serialClock = 1'b1;
			rxFrame[i] = progSerialOut;
			#6 serialClock = 1'b0;
		end
		// A released line flips so a stale bit is never read as data.
		progSerialIn = ~progSerialIn;
		@(posedge clock) done <= 1'b1;
		@(posedge clock iff !start) done <= 1'b0;
	end
endmodule : isp_prog_model

// ### sim/isp_port_checker.sv
/*
 * Pin-level checks of the programming port.
 * Assumes progResetN high clears the link between sessions.
 */
`timescale 1ns/1ps
module isp_port_checker
	import isp_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
	// Clocks and resets.
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic serialClock,
	input wire logic progResetN,
	// Watched pins.
	input wire logic progSerialIn,
	input wire logic progSerialOut,
	input wire logic writeDoneFlag,
	input wire logic cpuRun
);
	logic [COUNT_W-1:0] bitNum;
	logic [FRAME_LEN-1:0] inBits;
	logic [TIMER_W-1:0] lowCount;
	always_ff @(posedge serialClock or posedge progResetN) begin
		if (progResetN) begin
			bitNum <= '0;
			inBits <= '0;
		end else begin
			bitNum <= bitNum + COUNT_ONE;
			inBits <= {inBits[FRAME_LEN-2:0], progSerialIn};
		end
	end
	// Counts low cycles of the ready flag, cleared while it is high.
	always_ff @(posedge clock) begin
		if (sys_rst || writeDoneFlag)
			lowCount <= '0;
		else
			lowCount <= lowCount + 24'h000001;
	end
	property p_echo;
		@(posedge serialClock) disable iff (progResetN)
		(bitNum >= 5'h08 && bitNum < 5'h18) |-> progSerialOut == inBits[7];
	endproperty
	a_echo: assert property (p_echo)
		else $error("answer bit is not the echo of the byte before");
	property p_byte0;
		@(posedge serialClock) disable iff (progResetN)
		bitNum < 5'h08 |-> !progSerialOut;
	endproperty
	a_byte0: assert property (p_byte0)
		else $error("first answer byte is not zero");
	property p_cpu_hold;
		@(posedge clock) disable iff (sys_rst)
		!progResetN [*5] |-> !cpuRun;
	endproperty
	a_cpu_hold: assert property (p_cpu_hold)
		else $error("cpu runs while programming reset is low");
	property p_cpu_rise;
		@(posedge clock) disable iff (sys_rst)
		$rose(progResetN) |-> ##[1:4] cpuRun;
	endproperty
	a_cpu_rise: assert property (p_cpu_rise)
		else $error("cpu did not start after reset release");
	property p_write_len;
		@(posedge clock) disable iff (sys_rst)
		$rose(writeDoneFlag) |->
			(lowCount >= WRITE_CYCLES - 2 && lowCount <= WRITE_CYCLES + 2) ||
			(lowCount >= ERASE_CYCLES - 2 && lowCount <= ERASE_CYCLES + 2);
	endproperty
	a_write_len: assert property (p_write_len)
		else $error("busy period has a wrong length");
	property p_busy_max;
		@(posedge clock) disable iff (sys_rst)
		!writeDoneFlag |-> lowCount <= ERASE_CYCLES + 2;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("busy period runs too long");
	property p_low_min;
		@(posedge clock) disable iff (sys_rst)
		$fell(writeDoneFlag) |=> !writeDoneFlag [*8];
	endproperty
	a_low_min: assert property (p_low_min)
		else $error("busy period ended at once");
	property p_fall_prog;
		@(posedge clock) disable iff (sys_rst)
		$fell(writeDoneFlag) |-> !cpuRun && !progResetN;
	endproperty
	a_fall_prog: assert property (p_fall_prog)
		else $error("write started outside programming mode");
endmodule : isp_port_checker

// ### sim/isp_port_tb.sv
/*
 * Self-checking bench of the programming port with a programmer model.
 * Assumes the shortened write and erase counts set below.
 */
`timescale 1ns/1ps
module isp_port_tb
	import isp_pkg::*;
;
	localparam int WCYC = 200;
	localparam int ECYC = 400;
	localparam int LIMIT = 20000;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic progResetN = 1'b1;
	logic start = 1'b0;
	isp_frame_type txFrame = '0;
	isp_frame_type rxFrame;
	logic done, serialClock, progSerialIn, progSerialOut;
	logic writeDoneFlag, cpuRun;
	logic [CLK_SRC_W-1:0] clockSourceFuses;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	always #10 clock = ~clock;
	isp_port #(.WRITE_CYCLES(WCYC), .ERASE_CYCLES(ECYC)) i_isp_port (
		.clock(clock), .sys_rst(sys_rst), .serialClock(serialClock),
		.progResetN(progResetN), .progSerialIn(progSerialIn),
		.progSerialOut(progSerialOut), .writeDoneFlag(writeDoneFlag),
		.cpuRun(cpuRun), .clockSourceFuses(clockSourceFuses));
	isp_prog_model i_isp_prog_model (.clock(clock), .start(start),
		.txFrame(txFrame), .rxFrame(rxFrame), .done(done),
		.serialClock(serialClock), .progSerialIn(progSerialIn),
		.progSerialOut(progSerialOut));
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic send(input logic [7:0] op, a, b, d);
		txFrame <= '{op, a, b, d};
		start <= 1'b1;
		@(posedge clock);
		for (int n = 0; n < 200 && done !== 1'b1; n++)
			@(posedge clock);
		start <= 1'b0;
		@(posedge clock);
		@(posedge clock);
	endtask : send
	task automatic settle(input string what);
		send(OP_POLL, 8'h00, 8'h00, 8'h00);
		chk({what, " busy"}, 8'h01, {7'h00, rxFrame.data[0]});
		for (int n = 0; n < 100 && rxFrame.data[0] !== 1'b0; n++)
			send(OP_POLL, 8'h00, 8'h00, 8'h00);
		chk({what, " ready"}, 8'h00, {7'h00, rxFrame.data[0]});
		chk({what, " flag"}, 8'h01, {7'h00, writeDoneFlag});
	endtask : settle
	task automatic t_exit;
		progResetN <= 1'b1;
		repeat (4) @(posedge clock);
		chk("run after release", 8'h01, {7'h00, cpuRun});
		progResetN <= 1'b0;
		repeat (6) @(posedge clock);
		chk("halt in session", 8'h00, {7'h00, cpuRun});
		$display("test exit done");
	endtask : t_exit
	task automatic t_locked;
		send(OP_WRITE_EE, 8'h01, 8'h23, 8'h12);
		repeat (8) @(posedge clock);
		chk("locked write", 8'h01, {7'h00, writeDoneFlag});
		send(OP_READ_EE, 8'h01, 8'h23, 8'h5A);
		chk("locked read", 8'h23, rxFrame.data);
		$display("test locked done");
	endtask : t_locked
	task automatic t_enable;
		send(OP_ENABLE, ENABLE_ECHO, 8'h00, 8'h00);
		chk("enable echo", ENABLE_ECHO, rxFrame.addrLo);
		chk("opcode echo", OP_ENABLE, rxFrame.addrHi);
		chk("first byte", 8'h00, rxFrame.op);
		chk("fuse reset", 8'h0F, {4'h0, clockSourceFuses});
		send(OP_SIGNATURE, 8'h00, 8'h01, 8'h00);
		chk("signature", SIG_BYTE1, rxFrame.data);
		$display("test enable done");
	endtask : t_enable
	task automatic t_eeprom;
		send(OP_WRITE_EE, 8'h01, 8'h23, 8'hA5);
		settle("ee write");
		send(OP_WRITE_EE, 8'h01, 8'h23, 8'h5C);
		settle("ee rewrite");
		send(OP_LOAD_EE_PAGE, 8'h00, 8'h00, 8'h77);
		send(OP_LOAD_EE_PAGE, 8'h00, 8'h40, 8'h66);
		send(OP_WRITE_EE_PAGE, 8'h01, 8'h24, 8'h00);
		settle("ee page");
		send(OP_READ_EE, 8'h01, 8'h24, 8'h00);
		chk("ee page 0", 8'h77, rxFrame.data);
		send(OP_READ_EE, 8'h01, 8'h25, 8'h00);
		chk("ee page 1", 8'h66, rxFrame.data);
		send(OP_READ_EE, 8'h01, 8'h23, 8'h00);
		chk("ee read", 8'h5C, rxFrame.data);
		$display("test eeprom done");
	endtask : t_eeprom
	task automatic t_flash;
		send(OP_EXT_ADDR, 8'h00, 8'h00, 8'h00);
		send(OP_LOAD_PAGE_LO, 8'h00, 8'h03, 8'h34);
		send(OP_LOAD_PAGE_HI, 8'h00, 8'h03, 8'h12);
		send(OP_WRITE_PAGE, 8'h00, 8'h80, 8'h00);
		settle("page write");
		send(OP_READ_PROG_LO, 8'h00, 8'h83, 8'h00);
		chk("flash low", 8'h34, rxFrame.data);
		send(OP_READ_PROG_HI, 8'h00, 8'h83, 8'h00);
		chk("flash high", 8'h12, rxFrame.data);
		send(OP_READ_PROG_LO, 8'h00, 8'h03, 8'h00);
		chk("other page", ERASED_BYTE, rxFrame.data);
		$display("test flash done");
	endtask : t_flash
	task automatic t_erase;
		send(OP_ENABLE, SUB_FUSE_LO, 8'h00, 8'hF3);
		settle("fuse write");
		send(OP_READ_FUSE, 8'h00, 8'h00, 8'h00);
		chk("fuse read", 8'hF3, rxFrame.data);
		send(OP_ENABLE, {SUB_ERASE, 5'h00}, 8'h00, 8'h00);
		settle("erase");
		send(OP_READ_EE, 8'h01, 8'h23, 8'h00);
		chk("ee erased", ERASED_BYTE, rxFrame.data);
		send(OP_READ_PROG_HI, 8'h00, 8'h83, 8'h00);
		chk("flash erased", ERASED_BYTE, rxFrame.data);
		chk("fuse kept", 8'h03, {4'h0, clockSourceFuses});
		send(OP_READ_LOCK, 8'h00, 8'h00, 8'h00);
		chk("lock erased", ERASED_BYTE, rxFrame.data);
		$display("test erase done");
	endtask : t_erase
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		t_exit();
		t_locked();
		t_enable();
		t_eeprom();
		t_flash();
		t_erase();
		t_exit();
		t_locked();
		wrap_up();
	end
endmodule : isp_port_tb
bind isp_port isp_port_checker #(.WRITE_CYCLES(WRITE_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)) i_isp_port_checker (.clock(clock),
	.sys_rst(sys_rst), .serialClock(serialClock), .progResetN(progResetN),
	.progSerialIn(progSerialIn), .progSerialOut(progSerialOut),
	.writeDoneFlag(writeDoneFlag), .cpuRun(cpuRun));
